/* verilog/rssr_pkg.sv */
/*
  Constants for the power and reset control register bank.
  Assumes a single 200 MHz core clock and a byte-wide register port.
*/
package rssr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RSSR_ADDR_PAGE = 8'h00;
  localparam logic [7:0] RSSR_ADDR_SOFT_RESET = 8'h01;
  localparam logic [7:0] RSSR_ADDR_SLEEP_CFG = 8'h02;
  localparam logic [7:0] RSSR_ADDR_SHUTDOWN_CONFIG = 8'h05;
  localparam logic [7:0] RSSR_PAGE_ZERO = 8'h00;
  localparam logic [7:0] RSSR_PAGE_RST = 8'h00;
  localparam logic [7:0] RSSR_SLEEP_CFG_RST = 8'h00;
  localparam logic [7:0] RSSR_SHUTDOWN_CONFIG_RST = 8'h05;
  localparam logic [7:0] RSSR_SLEEP_CFG_WMASK = 8'hFD;
  localparam logic [7:0] RSSR_SHUTDOWN_CONFIG_WMASK = 8'h3F;
  localparam logic [7:0] RSSR_READ_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RSSR_SOFT_RESET_BIT = 0;
  localparam int RSSR_WAKE_BIT = 0;
  localparam int RSSR_BCAST_BIT = 2;
  localparam int RSSR_REF_LSB = 3;
  localparam int RSSR_ANALOG_RAIL_BIT = 7;
  localparam int RSSR_INCAP_LSB = 4;
  localparam logic [6:0] RSSR_BCAST_ADDR = 7'h4C;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RSSR_CLK_MHZ = 200;
  localparam int RSSR_REF_US_0 = 3500;
  localparam int RSSR_REF_US_1 = 10000;
  localparam int RSSR_REF_US_2 = 50000;
  localparam int RSSR_REF_US_3 = 100000;
  localparam int RSSR_INCAP_US_0 = 2500;
  localparam int RSSR_INCAP_US_1 = 12500;
  localparam int RSSR_INCAP_US_2 = 25000;
  localparam int RSSR_INCAP_US_3 = 50000;
  localparam int RSSR_CNT_W = 25;

  typedef enum logic [1:0] {
    RSSR_ST_ASLEEP,
    RSSR_ST_REF,
    RSSR_ST_INCAP,
    RSSR_ST_AWAKE
  } rssr_state_t;
endpackage

/* verilog/rssr_regs.sv */
/*
  Power and reset control register bank with wake-up precharge sequencer.
  Assumes the two-wire bus front end delivers byte accesses on CLK.
*/
// Summary of operation
// - Soft reset request bit clears itself one cycle after it is set.
// - Writing one resets every register to default; writing zero does nothing.
// - Device sleeps while wake select is zero; wakes only when it is one.
// - Broadcast enable makes the device answer at fixed address 1001100.
// - Reference precharge code selects 3.5, 10, 50 or 100 ms.
// - Input cap precharge code selects 2.5, 12.5, 25 or 50 ms.
// - Analog supply bit: zero external rail, one internal regulator.
// - Shutdown register at 0x5, resets to 0x5, top two bits read zero.
// - Page register at offset zero selects page for other accesses.
`timescale 1ns/1ps
module rssr_regs
  import rssr_pkg::*;
#(
  parameter int REF_CYC_0 = RSSR_REF_US_0 * RSSR_CLK_MHZ,
  parameter int REF_CYC_1 = RSSR_REF_US_1 * RSSR_CLK_MHZ,
  parameter int REF_CYC_2 = RSSR_REF_US_2 * RSSR_CLK_MHZ,
  parameter int REF_CYC_3 = RSSR_REF_US_3 * RSSR_CLK_MHZ,
  parameter int INCAP_CYC_0 = RSSR_INCAP_US_0 * RSSR_CLK_MHZ,
  parameter int INCAP_CYC_1 = RSSR_INCAP_US_1 * RSSR_CLK_MHZ,
  parameter int INCAP_CYC_2 = RSSR_INCAP_US_2 * RSSR_CLK_MHZ,
  parameter int INCAP_CYC_3 = RSSR_INCAP_US_3 * RSSR_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic [7:0] PAGE,
  output logic SOFT_RESET_ACTIVE,
  output logic SLEEP,
  output logic ANALOG_RAIL_INTERNAL,
  output logic BROADCAST_EN,
  output logic [6:0] BROADCAST_ADDR,
  output logic REF_PRECHARGE,
  output logic INCAP_PRECHARGE
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [RSSR_CNT_W-1:0] ref_len(input logic [1:0] c);
    unique case (c)
      2'h0: ref_len = RSSR_CNT_W'(REF_CYC_0);
      2'h1: ref_len = RSSR_CNT_W'(REF_CYC_1);
      2'h2: ref_len = RSSR_CNT_W'(REF_CYC_2);
      2'h3: ref_len = RSSR_CNT_W'(REF_CYC_3);
    endcase
  endfunction

  function automatic logic [RSSR_CNT_W-1:0] incap_len(input logic [1:0] c);
    unique case (c)
      2'h0: incap_len = RSSR_CNT_W'(INCAP_CYC_0);
      2'h1: incap_len = RSSR_CNT_W'(INCAP_CYC_1);
      2'h2: incap_len = RSSR_CNT_W'(INCAP_CYC_2);
      2'h3: incap_len = RSSR_CNT_W'(INCAP_CYC_3);
    endcase
  endfunction

  // Page zero holds everything but the page register itself
  function automatic logic hit(input logic [7:0] a, input logic [7:0] pg,
                               input logic [7:0] target);
    hit = (a == target) && (pg == RSSR_PAGE_ZERO);
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] page_reg, page_next;
  logic [7:0] sleep_cfg_reg, sleep_cfg_next;
  logic [7:0] shutdown_config_reg, shutdown_config_next;
  logic srst_reg, srst_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] ref_code, incap_code;

  assign ref_code = sleep_cfg_reg[RSSR_REF_LSB +: 2];
  assign incap_code = shutdown_config_reg[RSSR_INCAP_LSB +: 2];

  always_comb begin
    page_next = page_reg;
    sleep_cfg_next = sleep_cfg_reg;
    shutdown_config_next = shutdown_config_reg;
    srst_next = 1'b0;
    rdata_next = rdata_reg;
    if (srst_reg) begin
      // Whole bank back to defaults; a write in this cycle is dropped
      page_next = RSSR_PAGE_RST;
      sleep_cfg_next = RSSR_SLEEP_CFG_RST;
      shutdown_config_next = RSSR_SHUTDOWN_CONFIG_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == RSSR_ADDR_PAGE) begin
        page_next = REG_WDATA;
      end
      if (hit(REG_ADDR, page_reg, RSSR_ADDR_SOFT_RESET)) begin
        srst_next = REG_WDATA[RSSR_SOFT_RESET_BIT];
      end
      if (hit(REG_ADDR, page_reg, RSSR_ADDR_SLEEP_CFG)) begin
        sleep_cfg_next = REG_WDATA & RSSR_SLEEP_CFG_WMASK;
      end
      if (hit(REG_ADDR, page_reg, RSSR_ADDR_SHUTDOWN_CONFIG)) begin
        shutdown_config_next = REG_WDATA & RSSR_SHUTDOWN_CONFIG_WMASK;
      end
    end
    if (REG_RD) begin
      rdata_next = RSSR_READ_ZERO;
      if (REG_ADDR == RSSR_ADDR_PAGE) begin
        rdata_next = page_reg;
      end else if (hit(REG_ADDR, page_reg, RSSR_ADDR_SOFT_RESET)) begin
        rdata_next = {7'h00, srst_reg};
      end else if (hit(REG_ADDR, page_reg, RSSR_ADDR_SLEEP_CFG)) begin
        rdata_next = sleep_cfg_reg;
      end else if (hit(REG_ADDR, page_reg, RSSR_ADDR_SHUTDOWN_CONFIG)) begin
        rdata_next = shutdown_config_reg;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      page_reg <= RSSR_PAGE_RST;
      sleep_cfg_reg <= RSSR_SLEEP_CFG_RST;
      shutdown_config_reg <= RSSR_SHUTDOWN_CONFIG_RST;
      srst_reg <= 1'b0;
      rdata_reg <= RSSR_READ_ZERO;
    end else begin
      page_reg <= page_next;
      sleep_cfg_reg <= sleep_cfg_next;
      shutdown_config_reg <= shutdown_config_next;
      srst_reg <= srst_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up precharge sequencer
  // ----------------------------------------------------------------
  // Reference first: the input caps charge toward a settled reference
  rssr_state_t state_reg, state_next;
  logic [RSSR_CNT_W-1:0] cnt_reg, cnt_next;
  logic wake;

  assign wake = sleep_cfg_reg[RSSR_WAKE_BIT];

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!wake) begin
      state_next = RSSR_ST_ASLEEP;
      cnt_next = '0;
    end else begin
      unique case (state_reg)
        RSSR_ST_ASLEEP: begin
          state_next = RSSR_ST_REF;
          cnt_next = ref_len(ref_code) - 1'b1;
        end
        RSSR_ST_REF: begin
          if (cnt_reg == '0) begin
            state_next = RSSR_ST_INCAP;
            cnt_next = incap_len(incap_code) - 1'b1;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        RSSR_ST_INCAP: begin
          if (cnt_reg == '0) begin
            state_next = RSSR_ST_AWAKE;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        RSSR_ST_AWAKE: begin
          state_next = RSSR_ST_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= RSSR_ST_ASLEEP;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic sleep_reg, analog_rail_reg, bcast_reg, refq_reg, incq_reg;
  logic [6:0] baddr_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sleep_reg <= 1'b1;
      analog_rail_reg <= 1'b0;
      bcast_reg <= 1'b0;
      baddr_reg <= RSSR_BCAST_ADDR;
      refq_reg <= 1'b0;
      incq_reg <= 1'b0;
    end else begin
      sleep_reg <= !wake;
      analog_rail_reg <= sleep_cfg_reg[RSSR_ANALOG_RAIL_BIT];
      bcast_reg <= sleep_cfg_reg[RSSR_BCAST_BIT];
      baddr_reg <= RSSR_BCAST_ADDR;
      refq_reg <= (state_next == RSSR_ST_REF);
      incq_reg <= (state_next == RSSR_ST_INCAP);
    end
  end

  assign REG_RDATA = rdata_reg;
  assign PAGE = page_reg;
  assign SOFT_RESET_ACTIVE = srst_reg;
  assign SLEEP = sleep_reg;
  assign ANALOG_RAIL_INTERNAL = analog_rail_reg;
  assign BROADCAST_EN = bcast_reg;
  assign BROADCAST_ADDR = baddr_reg;
  assign REF_PRECHARGE = refq_reg;
  assign INCAP_PRECHARGE = incq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic wr_srst;
  assign wr_srst = REG_WR && !srst_reg
                   && hit(REG_ADDR, page_reg, RSSR_ADDR_SOFT_RESET);

  property p_self_clear;
    @(posedge CLK) disable iff (!NRST) srst_reg |=> !srst_reg;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("soft reset bit did not clear");

  property p_reset_defaults;
    @(posedge CLK) disable iff (!NRST)
      srst_reg |=> (sleep_cfg_reg == RSSR_SLEEP_CFG_RST)
        && (shutdown_config_reg == RSSR_SHUTDOWN_CONFIG_RST) && (page_reg == RSSR_PAGE_RST);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("soft reset left a register off default");

  property p_zero_no_reset;
    @(posedge CLK) disable iff (!NRST)
      wr_srst && !REG_WDATA[RSSR_SOFT_RESET_BIT] |=> !srst_reg;
  endproperty
  a_zero_no_reset: assert property (p_zero_no_reset)
    else $error("writing zero started a soft reset");

  property p_srst_upper_zero;
    @(posedge CLK) disable iff (!NRST)
      REG_RD && hit(REG_ADDR, page_reg, RSSR_ADDR_SOFT_RESET)
      |=> REG_RDATA[7:1] == 7'h00;
  endproperty
  a_srst_upper_zero: assert property (p_srst_upper_zero)
    else $error("soft reset upper bits not zero");

  property p_sleep;
    @(posedge CLK) disable iff (!NRST)
      !wake |=> SLEEP && !REF_PRECHARGE && !INCAP_PRECHARGE;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("device awake with wake select clear");

  property p_wake;
    @(posedge CLK) disable iff (!NRST)
      $rose(wake) |=> !SLEEP ##0 REF_PRECHARGE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not start precharge");

  property p_bcast;
    @(posedge CLK) disable iff (!NRST)
      ##1 (BROADCAST_EN == $past(sleep_cfg_reg[RSSR_BCAST_BIT]))
      && (BROADCAST_ADDR == RSSR_BCAST_ADDR);
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast enable or address wrong");

  property p_ref_len;
    @(posedge CLK) disable iff (!NRST)
      state_reg == RSSR_ST_ASLEEP && wake
      |=> cnt_reg == ref_len($past(ref_code)) - 1'b1;
  endproperty
  a_ref_len: assert property (p_ref_len)
    else $error("reference precharge length wrong");

  property p_incap_len;
    @(posedge CLK) disable iff (!NRST)
      state_reg == RSSR_ST_REF && cnt_reg == '0 && wake
      |=> state_reg == RSSR_ST_INCAP
        && cnt_reg == incap_len($past(incap_code)) - 1'b1;
  endproperty
  a_incap_len: assert property (p_incap_len)
    else $error("input cap precharge length wrong");

  property p_analog_rail;
    @(posedge CLK) disable iff (!NRST)
      ##1 ANALOG_RAIL_INTERNAL == $past(sleep_cfg_reg[RSSR_ANALOG_RAIL_BIT]);
  endproperty
  a_analog_rail: assert property (p_analog_rail)
    else $error("analog rail select mismatch");

  property p_shdn_top;
    @(posedge CLK) disable iff (!NRST)
      REG_RD && hit(REG_ADDR, page_reg, RSSR_ADDR_SHUTDOWN_CONFIG)
      |=> REG_RDATA[7:6] == 2'h0;
  endproperty
  a_shdn_top: assert property (p_shdn_top)
    else $error("shutdown top bits not zero");

  property p_page;
    @(posedge CLK) disable iff (!NRST)
      REG_RD && REG_ADDR != RSSR_ADDR_PAGE && page_reg != RSSR_PAGE_ZERO
      |=> REG_RDATA == RSSR_READ_ZERO;
  endproperty
  a_page: assert property (p_page)
    else $error("access outside page zero returned data");

  c_soft_reset: cover property (@(posedge CLK) disable iff (!NRST)
    wr_srst && REG_WDATA[RSSR_SOFT_RESET_BIT] ##1 srst_reg ##1 !srst_reg);
  c_full_wake: cover property (@(posedge CLK) disable iff (!NRST)
    REF_PRECHARGE ##1 INCAP_PRECHARGE);
  c_awake: cover property (@(posedge CLK) disable iff (!NRST)
    state_reg == RSSR_ST_AWAKE);
  c_bcast: cover property (@(posedge CLK) disable iff (!NRST)
    $rose(BROADCAST_EN));
endmodule // rssr_regs

/* tb/rssr_host.sv */
/*
  Host side model of the register port: byte writes and reads.
  Assumes the bench clock and that inputs change on the falling edge.
*/
`timescale 1ns/1ps
module rssr_host (
  input wire logic CLK,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [7:0] REG_RDATA
);
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h01) v[7:1] = 7'h00;
    if (a == 8'h02) v[1] = 1'b0;
    if (a == 8'h05) v[3:0] = 4'h5;
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
    REG_WDATA = ~v; // Stale data never looks valid
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    d = REG_RDATA;
  endtask
endmodule // rssr_host

/* tb/rssr_regs_tb_top.sv */
/*
  Self-checking bench for the power and reset control registers.
  Assumes short precharge counts set through the design parameters.
*/
`timescale 1ns/1ps
module reset_sleep_shutdown_regs_tb_top;
  import rssr_pkg::*;
  localparam int REF_LEN [4] = '{10, 20, 30, 40};
  localparam int INC_LEN [4] = '{5, 15, 25, 35};
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] addr, wdata, rdata, page;
  logic wr, rd, sra, slp, rail, bcen, refp, incp;
  logic [6:0] bcaddr;
  int failures = 0;
  int compares = 0;
  int n, r;

  always #2.5 CLK = ~CLK;

  rssr_host host_u (.CLK(CLK), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  rssr_regs #(.REF_CYC_0(REF_LEN[0]), .REF_CYC_1(REF_LEN[1]),
    .REF_CYC_2(REF_LEN[2]), .REF_CYC_3(REF_LEN[3]),
    .INCAP_CYC_0(INC_LEN[0]), .INCAP_CYC_1(INC_LEN[1]),
    .INCAP_CYC_2(INC_LEN[2]), .INCAP_CYC_3(INC_LEN[3])) dut_u (
    .CLK(CLK), .NRST(NRST), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PAGE(page),
    .SOFT_RESET_ACTIVE(sra), .SLEEP(slp), .ANALOG_RAIL_INTERNAL(rail),
    .BROADCAST_EN(bcen), .BROADCAST_ADDR(bcaddr),
    .REF_PRECHARGE(refp), .INCAP_PRECHARGE(incp));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask

  // Length of the next high phase of one precharge output
  task automatic meas(input bit inc, output int len);
    int k;
    len = 0;
    for (k = 0; k < 400 && (inc ? incp : refp) !== 1'b1; k++) begin
      @(negedge CLK);
    end
    if (k == 400) begin
      failures++;
      report_and_stop();
    end
    while ((inc ? incp : refp) === 1'b1 && len < 400) begin
      len++;
      @(negedge CLK);
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(negedge CLK);
    NRST = 1'b1;
    rdc(8'h01, 8'h00);
    rdc(8'h02, 8'h00);
    rdc(8'h05, 8'h05);
    chk({7'h00, slp}, 8'h01);
    chk({1'b0, bcaddr}, 8'h4C);
    chk({7'h00, bcen}, 8'h00);
    chk({7'h00, rail}, 8'h00);
    host_u.wr(8'h02, 8'h84);
    rdc(8'h02, 8'h84);
    chk({6'h00, rail, bcen}, 8'h03);
    chk({7'h00, slp}, 8'h01);
    rdc(8'h03, 8'h00);
    for (r = 0; r < 4; r++) begin
      host_u.wr(8'h05, 8'(((3 - r) << 4) | 5));
      host_u.wr(8'h02, 8'((r << 3) | 1));
      meas(1'b0, n);
      chk(8'(n), 8'(REF_LEN[r]));
      meas(1'b1, n);
      chk(8'(n), 8'(INC_LEN[3 - r]));
      chk({6'h00, slp, refp}, 8'h00);
      host_u.wr(8'h02, 8'h00);
      @(negedge CLK);
      chk({7'h00, slp}, 8'h01);
    end
    host_u.wr(8'h02, 8'h01);
    meas(1'b0, n);
    chk(8'(n), 8'(REF_LEN[0]));
    // Code change after phase entry must not restart the reference phase
    host_u.wr(8'h02, 8'h19);
    repeat (8) @(negedge CLK);
    chk({6'h00, slp, refp | incp}, 8'h00);
    host_u.wr(8'h02, 8'h00);
    host_u.wr(8'h02, 8'h19);
    @(negedge CLK);
    chk({6'h00, slp, refp}, 8'h01);
    host_u.wr(8'h02, 8'h00);
    repeat (2) @(negedge CLK);
    chk({6'h00, slp, refp | incp}, 8'h02);
    host_u.wr(8'h05, 8'hF5);
    rdc(8'h05, 8'h35);
    host_u.wr(8'h00, 8'h01);
    chk(page, 8'h01);
    rdc(8'h05, 8'h00);
    host_u.wr(8'h05, 8'h25);
    host_u.wr(8'h00, 8'h00);
    rdc(8'h05, 8'h35);
    host_u.wr(8'h01, 8'h00);
    rdc(8'h05, 8'h35);
    host_u.wr(8'h02, 8'h8C);
    rdc(8'h02, 8'h8C);
    host_u.wr(8'h01, 8'h01);
    chk({7'h00, sra}, 8'h01);
    @(negedge CLK);
    chk({7'h00, sra}, 8'h00);
    rdc(8'h01, 8'h00);
    rdc(8'h02, 8'h00);
    rdc(8'h05, 8'h05);
    chk({5'h00, rail, bcen, slp}, 8'h01);
    report_and_stop();
  end
endmodule // reset_sleep_shutdown_regs_tb_top
